// file: hw/gtab_map.svh
// offsets of run bits, reset values and count-source divider terminals for the timer bank
`ifndef GTAB_MAP_SVH
`define GTAB_MAP_SVH

`define GTAB_A0_RUN_BIT    3'd0
`define GTAB_B_RUN_LOW_BIT 3'd5
`define GTAB_CNT_RST       16'h0000
`define GTAB_CNT_MAX       16'hffff
`define GTAB_DIV_TERM_1    8'h00
`define GTAB_DIV_TERM_8    8'h07
`define GTAB_DIV_TERM_32   8'h1f
`define GTAB_DIV_TERM_256  8'hff

`endif

// file: hw/gtab_pkg.sv
// types and shared arithmetic for the timer bank
package gtab_pkg;

  typedef enum logic [1:0] {GTAB_A_TIMER, GTAB_A_EVENT, GTAB_A_ONESHOT, GTAB_A_PWM} gtab_amode_t;
  typedef enum logic [1:0] {GTAB_B_TIMER, GTAB_B_EVENT, GTAB_B_MEASURE, GTAB_B_SPARE} gtab_bmode_t;
  typedef enum logic {GTAB_OS_IDLE, GTAB_OS_RUN} gtab_os_t;

  typedef struct packed {
    logic [7:0]  pre;
    logic        tick;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic        out;
    logic        irq;
    logic        irq_pend;
    logic        run_q;
    gtab_amode_t mode_q;
    logic        trig_q;
    logic        start_pend;
    logic        retrig;
    logic        reload_nxt;
    gtab_os_t    os;
  } gtab_a_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] rld;
    logic        run_q;
    logic        pin_q;
    logic        first;
    logic        ovf;
    logic        ovf_aged;
    logic        irq;
    logic [1:0]  sel;
    gtab_bmode_t mode;
  } gtab_b_state_t;

  function automatic logic [15:0] gtab_dec(input logic [15:0] v);
    gtab_dec = v - 16'h0001;
  endfunction : gtab_dec

  function automatic logic [15:0] gtab_inc(input logic [15:0] v);
    gtab_inc = v + 16'h0001;
  endfunction : gtab_inc

endpackage : gtab_pkg

// file: hw/gtab_meas.sv
// second-family timer: timer, event counter and pulse period/width measurement
`timescale 1ns/1ps
`include "gtab_map.svh"

module gtab_meas (
  input  logic        clk,
  input  logic        sys_rst,
  input  logic        tick,
  input  logic        run,
  input  logic [1:0]  second_family_mode_reg,
  input  logic        measure_select_hi,
  input  logic        measure_select_lo,
  input  logic        mode_wr,
  input  logic        cnt_wr_en,
  input  logic [15:0] cnt_wr_data,
  input  logic        irq_clr,
  input  logic        event_pin,
  output logic [15:0] cnt_rd_data,
  output logic        overflow_flag,
  output logic        irq_request_flag
);

  gtab_pkg::gtab_b_state_t st_ff;
  gtab_pkg::gtab_b_state_t nxt_st;
  logic                    valid_edge;
  logic                    ovf_now;
  logic                    irq_set;

  always_comb
  begin
    nxt_st     = st_ff;
    irq_set    = 1'b0;
    nxt_st.run_q = run;
    nxt_st.pin_q = event_pin;
    // width mode takes both edges; period modes take one edge only
    case (st_ff.sel)
      2'b00:   valid_edge = !event_pin && st_ff.pin_q;
      2'b01:   valid_edge = event_pin && !st_ff.pin_q;
      default: valid_edge = event_pin != st_ff.pin_q;
    endcase
    ovf_now = run && st_ff.mode == gtab_pkg::GTAB_B_MEASURE && tick && st_ff.cnt == `GTAB_CNT_MAX;
    if (tick && st_ff.ovf)
      nxt_st.ovf_aged = 1'b1;
    if (mode_wr)
    begin
      nxt_st.mode = gtab_pkg::gtab_bmode_t'(second_family_mode_reg);
      nxt_st.sel  = {measure_select_hi, measure_select_lo};
      if (run && st_ff.run_q && {measure_select_hi, measure_select_lo} != st_ff.sel)
        irq_set = 1'b1; // R18
      if (st_ff.ovf_aged)
      begin
        nxt_st.ovf      = 1'b0; // R15
        nxt_st.ovf_aged = 1'b0;
      end
    end
    if (cnt_wr_en)
    begin
      nxt_st.rld = cnt_wr_data;
      if (!run)
        nxt_st.cnt = cnt_wr_data; // R04
    end
    if (run && !st_ff.run_q)
      nxt_st.first = 1'b1;
    else if (run)
    begin
      case (st_ff.mode)
        gtab_pkg::GTAB_B_TIMER, gtab_pkg::GTAB_B_EVENT:
        begin
          if ((st_ff.mode == gtab_pkg::GTAB_B_TIMER) ? tick : (event_pin && !st_ff.pin_q))
          begin
            if (st_ff.cnt == `GTAB_CNT_RST)
            begin
              nxt_st.cnt = st_ff.rld; // R03
              irq_set    = 1'b1;
            end
            else
              nxt_st.cnt = gtab_pkg::gtab_dec(st_ff.cnt);
          end
        end
        gtab_pkg::GTAB_B_MEASURE:
        begin
          // counter is not cleared at start, so an early overflow is possible
          if (ovf_now)
          begin
            nxt_st.cnt      = `GTAB_CNT_RST;
            nxt_st.ovf      = 1'b1; // R17
            nxt_st.ovf_aged = 1'b0;
            irq_set         = 1'b1;
          end
          else if (tick)
            nxt_st.cnt = gtab_pkg::gtab_inc(st_ff.cnt);
          if (valid_edge && !(ovf_now && !st_ff.sel[1])) // R20
          begin
            nxt_st.rld   = st_ff.cnt; // R19
            nxt_st.cnt   = `GTAB_CNT_RST;
            nxt_st.first = 1'b0;
            if (!st_ff.first)
              irq_set = 1'b1; // R16
          end
        end
        default: ;
      endcase
    end
    nxt_st.irq = (st_ff.irq && !irq_clr) || irq_set;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign cnt_rd_data      = st_ff.cnt;
  assign overflow_flag    = st_ff.ovf;
  assign irq_request_flag = st_ff.irq;

  meas_first_a: assert property (@(posedge clk) disable iff (sys_rst) // R16
    (run && st_ff.run_q && st_ff.mode == gtab_pkg::GTAB_B_MEASURE && st_ff.first && valid_edge
     && !ovf_now && !st_ff.irq && !mode_wr) |=> (!st_ff.irq && !st_ff.first))
    else $error("first measured edge raised a request");

  ovf_edge_a: assert property (@(posedge clk) disable iff (sys_rst) // R20
    (ovf_now && !st_ff.sel[1] && valid_edge && !cnt_wr_en) |=> (st_ff.irq && st_ff.rld == $past(st_ff.rld)))
    else $error("edge at overflow was captured");

  sel_change_a: assert property (@(posedge clk) disable iff (sys_rst) // R18
    (run && st_ff.run_q && mode_wr && {measure_select_hi, measure_select_lo} != st_ff.sel) |=> st_ff.irq)
    else $error("select change gave no request");

  ovf_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // R15
    (mode_wr && st_ff.ovf_aged && !ovf_now) |=> !st_ff.ovf)
    else $error("overflow flag not cleared by mode write");

endmodule : gtab_meas

// file: hw/gtab_timer_top.sv
// first-family timer channel with divider, plus one second-family channel
`timescale 1ns/1ps
`include "gtab_map.svh"

// Contract
// (R01) timers stopped after reset; run bit starts
// (R02) reconfigure only while stopped
// (R03) timer mode reads return live count
// (R04) stopped write reads back until start
// (R05) event reload may read ffff or 0000
// (R06) one-shot stop: reload, output low, late request
// (R07) one-shot start waits up to one tick
// (R08) entering one-shot from reset/timer/event requests
// (R09) retrigger: one more decrement, then reload
// (R10) retrigger spaced one tick after trigger
// (R11) no external retrigger 300 ns before zero
// (R12) entering pwm from reset/timer/event requests
// (R13) pwm stop: high output falls and requests
// (R14) second-family run bits at 7..5
// (R15) overflow clear needs one tick after set
// (R16) first measured edge: no request
// (R17) early overflow before any edge allowed
// (R18) measure select change may request
// (R19) width mode measures both levels unmarked
// (R20) overflow with edge: one request, edge lost; width mode captures the edge
// (R21) no counter write at motor underflow
// (R22) 16-bit down counter reloads on underflow
module gtab_timer_top #(
  parameter int B_INDEX = 0
) (
  input  logic        clk,
  input  logic        sys_rst,
  input  logic [7:0]  count_start_reg_a,
  input  logic [7:0]  count_start_reg_b,
  input  logic [1:0]  first_family_mode_reg,
  input  logic [1:0]  count_src_sel,
  input  logic        up_down_select_reg,
  input  logic        trigger_select_low,
  input  logic        one_shot_start_reg,
  input  logic        a_cnt_wr_en,
  input  logic [15:0] a_cnt_wr_data,
  input  logic        a_irq_clr,
  input  logic        timer_trigger_pin,
  output logic        timer_output_pin,
  output logic [15:0] a_cnt_rd_data,
  output logic        a_irq_request_flag,
  input  logic [1:0]  second_family_mode_reg,
  input  logic        measure_select_hi,
  input  logic        measure_select_lo,
  input  logic        b_mode_wr,
  input  logic        b_cnt_wr_en,
  input  logic [15:0] b_cnt_wr_data,
  input  logic        b_irq_clr,
  input  logic        b_event_pin,
  output logic [15:0] b_cnt_rd_data,
  output logic        overflow_flag,
  output logic        b_irq_request_flag
);

  gtab_pkg::gtab_a_state_t st_ff;
  gtab_pkg::gtab_a_state_t nxt_st;
  gtab_pkg::gtab_amode_t   a_mode;
  logic                    first_family_run_bit;
  logic                    second_family_run_bit;
  logic [7:0]              div_term;
  logic                    trig_rise;
  logic                    start_evt;
  logic                    a_irq_set;

  function automatic logic [7:0] gtab_div_term(input logic [1:0] sel);
    case (sel)
      2'b00:   gtab_div_term = `GTAB_DIV_TERM_1;
      2'b01:   gtab_div_term = `GTAB_DIV_TERM_8;
      2'b10:   gtab_div_term = `GTAB_DIV_TERM_32;
      default: gtab_div_term = `GTAB_DIV_TERM_256;
    endcase
  endfunction : gtab_div_term

  // second-family run bits: timers 2..0 in reg a, 5..3 in reg b, both at 7..5
  function automatic logic gtab_b_run(input int idx, input logic [7:0] ra, input logic [7:0] rb);
    logic [2:0] pos;
    if (idx < 3)
    begin
      pos        = 3'(idx) + `GTAB_B_RUN_LOW_BIT;
      gtab_b_run = ra[pos];
    end
    else
    begin
      pos        = 3'(idx - 3) + `GTAB_B_RUN_LOW_BIT;
      gtab_b_run = rb[pos];
    end
  endfunction : gtab_b_run

  assign first_family_run_bit  = count_start_reg_a[`GTAB_A0_RUN_BIT];
  assign second_family_run_bit = gtab_b_run(B_INDEX, count_start_reg_a, count_start_reg_b); // R14
  assign a_mode                = gtab_pkg::gtab_amode_t'(first_family_mode_reg);
  assign div_term              = gtab_div_term(count_src_sel);
  assign trig_rise             = timer_trigger_pin && !st_ff.trig_q;
  assign start_evt             = trigger_select_low ? trig_rise : one_shot_start_reg;

  always_comb
  begin
    nxt_st    = st_ff;
    a_irq_set = 1'b0;
    // count source divider: one-cycle enable, shared with the second channel
    nxt_st.tick = 1'b0;
    if (st_ff.pre >= div_term)
    begin
      nxt_st.pre  = 8'h00;
      nxt_st.tick = 1'b1;
    end
    else
      nxt_st.pre = st_ff.pre + 8'h01;
    nxt_st.run_q    = first_family_run_bit;
    nxt_st.mode_q   = a_mode;
    nxt_st.trig_q   = timer_trigger_pin;
    nxt_st.irq_pend = 1'b0;
    if (st_ff.irq_pend)
      a_irq_set = 1'b1; // R06
    // mode_q resets to timer mode, so selection after reset counts as a switch
    if (a_mode != st_ff.mode_q && (a_mode == gtab_pkg::GTAB_A_ONESHOT || a_mode == gtab_pkg::GTAB_A_PWM)
        && (st_ff.mode_q == gtab_pkg::GTAB_A_TIMER || st_ff.mode_q == gtab_pkg::GTAB_A_EVENT))
      a_irq_set = 1'b1; // R08 R12
    if (a_cnt_wr_en)
    begin
      nxt_st.rld = a_cnt_wr_data;
      if (!first_family_run_bit)
        nxt_st.cnt = a_cnt_wr_data; // R04
    end
    if (st_ff.run_q && !first_family_run_bit)
    begin
      if (a_mode == gtab_pkg::GTAB_A_ONESHOT && st_ff.os == gtab_pkg::GTAB_OS_RUN)
      begin
        nxt_st.cnt        = st_ff.rld; // R06
        nxt_st.out        = 1'b0;
        nxt_st.os         = gtab_pkg::GTAB_OS_IDLE;
        nxt_st.retrig     = 1'b0;
        nxt_st.reload_nxt = 1'b0;
        nxt_st.start_pend = 1'b0;
        nxt_st.irq_pend   = 1'b1;
      end
      else if (a_mode == gtab_pkg::GTAB_A_PWM && st_ff.out)
      begin
        nxt_st.out = 1'b0; // R13
        a_irq_set  = 1'b1;
      end
    end
    else if (first_family_run_bit) // R01
    begin
      case (a_mode)
        gtab_pkg::GTAB_A_TIMER:
        begin
          if (st_ff.tick)
          begin
            if (st_ff.cnt == `GTAB_CNT_RST)
            begin
              nxt_st.cnt = st_ff.rld; // R03 R22
              a_irq_set  = 1'b1;
            end
            else
              nxt_st.cnt = gtab_pkg::gtab_dec(st_ff.cnt);
          end
        end
        gtab_pkg::GTAB_A_EVENT:
        begin
          if (trig_rise)
          begin
            if (up_down_select_reg)
            begin
              if (st_ff.cnt == `GTAB_CNT_MAX)
              begin
                nxt_st.cnt = st_ff.rld; // R05
                a_irq_set  = 1'b1;
              end
              else
                nxt_st.cnt = gtab_pkg::gtab_inc(st_ff.cnt);
            end
            else if (st_ff.cnt == `GTAB_CNT_RST)
            begin
              nxt_st.cnt = st_ff.rld; // R05
              a_irq_set  = 1'b1;
            end
            else
              nxt_st.cnt = gtab_pkg::gtab_dec(st_ff.cnt);
          end
        end
        gtab_pkg::GTAB_A_ONESHOT:
        begin
          if (st_ff.tick)
          begin
            if (st_ff.start_pend && st_ff.os == gtab_pkg::GTAB_OS_IDLE)
            begin
              nxt_st.os         = gtab_pkg::GTAB_OS_RUN; // R07
              nxt_st.out        = 1'b1;
              nxt_st.cnt        = st_ff.rld;
              nxt_st.start_pend = 1'b0;
            end
            else if (st_ff.os == gtab_pkg::GTAB_OS_RUN)
            begin
              if (st_ff.reload_nxt)
              begin
                nxt_st.cnt        = st_ff.rld; // R09
                nxt_st.reload_nxt = 1'b0;
              end
              else if (st_ff.retrig)
              begin
                nxt_st.cnt        = gtab_pkg::gtab_dec(st_ff.cnt); // R09
                nxt_st.reload_nxt = 1'b1;
                nxt_st.retrig     = 1'b0;
              end
              else if (st_ff.cnt == `GTAB_CNT_RST)
              begin
                nxt_st.os  = gtab_pkg::GTAB_OS_IDLE;
                nxt_st.out = 1'b0;
                nxt_st.cnt = st_ff.rld;
                a_irq_set  = 1'b1;
              end
              else
                nxt_st.cnt = gtab_pkg::gtab_dec(st_ff.cnt); // R22
            end
          end
          // a trigger landing on the tick that ends the count starts a fresh shot
          if (start_evt && !st_ff.start_pend)
          begin
            if (st_ff.os == gtab_pkg::GTAB_OS_RUN && nxt_st.os == gtab_pkg::GTAB_OS_RUN)
              nxt_st.retrig = 1'b1;
            else
              nxt_st.start_pend = 1'b1;
          end
        end
        gtab_pkg::GTAB_A_PWM:
        begin
          if (!st_ff.run_q)
          begin
            nxt_st.out = 1'b1;
            nxt_st.cnt = st_ff.rld;
          end
          else if (st_ff.tick)
          begin
            // low phase lasts the complement so the period stays fixed
            if (st_ff.cnt == `GTAB_CNT_RST)
            begin
              nxt_st.out = !st_ff.out;
              nxt_st.cnt = st_ff.out ? ~st_ff.rld : st_ff.rld;
              a_irq_set  = st_ff.out;
            end
            else
              nxt_st.cnt = gtab_pkg::gtab_dec(st_ff.cnt); // R22
          end
        end
        default: ;
      endcase
    end
    nxt_st.irq = (st_ff.irq && !a_irq_clr) || a_irq_set;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_ff <= '0; // R01
    else
      st_ff <= nxt_st;
  end

  assign timer_output_pin   = st_ff.out;
  assign a_cnt_rd_data      = st_ff.cnt;
  assign a_irq_request_flag = st_ff.irq;

  gtab_meas u_meas (
    .clk                    (clk),
    .sys_rst                (sys_rst),
    .tick                   (st_ff.tick),
    .run                    (second_family_run_bit),
    .second_family_mode_reg (second_family_mode_reg),
    .measure_select_hi      (measure_select_hi),
    .measure_select_lo      (measure_select_lo),
    .mode_wr                (b_mode_wr),
    .cnt_wr_en              (b_cnt_wr_en),
    .cnt_wr_data            (b_cnt_wr_data),
    .irq_clr                (b_irq_clr),
    .event_pin              (b_event_pin),
    .cnt_rd_data            (b_cnt_rd_data),
    .overflow_flag          (overflow_flag),
    .irq_request_flag       (b_irq_request_flag)
  );

  os_stop_a: assert property (@(posedge clk) disable iff (sys_rst) // R06
    (st_ff.run_q && !first_family_run_bit && a_mode == gtab_pkg::GTAB_A_ONESHOT
     && st_ff.os == gtab_pkg::GTAB_OS_RUN && !a_cnt_wr_en)
    |=> (!st_ff.out && st_ff.cnt == $past(st_ff.rld)) ##1 st_ff.irq)
    else $error("one-shot stop did not reload, drop output and request");

  pwm_stop_a: assert property (@(posedge clk) disable iff (sys_rst) // R13
    (st_ff.run_q && !first_family_run_bit && a_mode == gtab_pkg::GTAB_A_PWM && st_ff.out)
    |=> (!st_ff.out && st_ff.irq))
    else $error("pwm stop with high output did not fall and request");

  mode_irq_a: assert property (@(posedge clk) disable iff (sys_rst) // R08
    (a_mode == gtab_pkg::GTAB_A_ONESHOT && st_ff.mode_q == gtab_pkg::GTAB_A_TIMER) |=> st_ff.irq)
    else $error("entering one-shot gave no request");

  wr_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // R04
    (!first_family_run_bit && a_cnt_wr_en) |=> a_cnt_rd_data == $past(a_cnt_wr_data))
    else $error("stopped write not read back");

  stop_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // R01
    (!first_family_run_bit && !st_ff.run_q && !a_cnt_wr_en) |=> $stable(a_cnt_rd_data))
    else $error("stopped counter moved");

  retrig_a: assert property (@(posedge clk) disable iff (sys_rst) // R09
    (first_family_run_bit && st_ff.run_q && a_mode == gtab_pkg::GTAB_A_ONESHOT && st_ff.tick
     && st_ff.os == gtab_pkg::GTAB_OS_RUN && st_ff.retrig && !st_ff.reload_nxt && !a_cnt_wr_en)
    |=> (st_ff.reload_nxt && st_ff.cnt == gtab_pkg::gtab_dec($past(st_ff.cnt))))
    else $error("retrigger did not decrement before reload");

endmodule : gtab_timer_top

// file: tb/gtab_pins_model.sv
// far-side model: external trigger, event and measured pulse sources
`timescale 1ns/1ps

module gtab_pins_model (
  input  wire logic clk,
  output logic      trig_pin,
  output logic      event_pin
);

  initial
  begin
    trig_pin  = 1'h0;
    event_pin = 1'h0;
  end

  // every pulse is held several cycles and followed by a gap, so no retrigger
  // lands within one count tick of the last trigger or near the zero count
  task automatic trig_pulses(input int n, input int gap);
    repeat (n)
    begin
      @(posedge clk);
      #1 trig_pin = 1'h1;
      repeat (4) @(posedge clk);
      #1 trig_pin = 1'h0;
      repeat (gap) @(posedge clk);
    end
    #1;
  endtask : trig_pulses

  // measured pulse level, held for n cycles; short or long holds as asked
  task automatic hold_event(input logic v, input int n);
    @(posedge clk);
    #1 event_pin = v;
    repeat (n) @(posedge clk);
    #1;
  endtask : hold_event

endmodule : gtab_pins_model

// file: tb/gtab_timer_top_test.sv
// self-checking bench for the timer bank top
`timescale 1ns/1ps

module gtab_timer_top_test;

  logic        clk, sys_rst, up_down_select_reg, trigger_select_low, one_shot_start_reg;
  logic        a_cnt_wr_en, a_irq_clr, timer_trigger_pin, timer_output_pin, a_irq_request_flag;
  logic        measure_select_hi, measure_select_lo, b_mode_wr, b_cnt_wr_en, b_irq_clr;
  logic        b_event_pin, overflow_flag, b_irq_request_flag;
  logic [7:0]  count_start_reg_a, count_start_reg_b;
  logic [1:0]  first_family_mode_reg, count_src_sel, second_family_mode_reg;
  logic [15:0] a_cnt_wr_data, a_cnt_rd_data, b_cnt_wr_data, b_cnt_rd_data;
  int          n_mismatch, n_tests;
  logic [1:0]  frm [4] = '{2'h0, 2'h1, 2'h0, 2'h1};
  logic [1:0]  tgt [4] = '{2'h2, 2'h2, 2'h3, 2'h3};

  gtab_timer_top #(.B_INDEX(0)) u_gtab_timer_top (.clk, .sys_rst, .count_start_reg_a, .count_start_reg_b,
    .first_family_mode_reg, .count_src_sel, .up_down_select_reg, .trigger_select_low, .one_shot_start_reg,
    .a_cnt_wr_en, .a_cnt_wr_data, .a_irq_clr, .timer_trigger_pin, .timer_output_pin, .a_cnt_rd_data,
    .a_irq_request_flag, .second_family_mode_reg, .measure_select_hi, .measure_select_lo, .b_mode_wr,
    .b_cnt_wr_en, .b_cnt_wr_data, .b_irq_clr, .b_event_pin, .b_cnt_rd_data, .overflow_flag,
    .b_irq_request_flag);

  gtab_pins_model u_gtab_pins_model (.clk, .trig_pin(timer_trigger_pin), .event_pin(b_event_pin));

  always #2.5 clk = ~clk;

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask : chk1

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  function automatic logic [15:0] pick(input int w);
    case (w)
      0: pick = a_cnt_rd_data;
      1: pick = {15'h0000, timer_output_pin};
      2: pick = {15'h0000, a_irq_request_flag};
      3: pick = b_cnt_rd_data;
      default: pick = {15'h0000, b_irq_request_flag};
    endcase
  endfunction : pick

  // bounded wait, then a compare so a hang shows up as a mismatch
  task automatic wait_on(input int w, input logic [15:0] v, input int bound);
    int k;
    k = 0;
    while (pick(w) !== v && k < bound)
    begin
      cyc(1);
      k++;
    end
    chk16(pick(w), v);
  endtask : wait_on

  task automatic wr(input logic b, input logic [15:0] v);
    a_cnt_wr_data = v;
    b_cnt_wr_data = v;
    a_cnt_wr_en = ~b;
    b_cnt_wr_en = b;
    cyc(1);
    a_cnt_wr_en = 1'h0;
    b_cnt_wr_en = 1'h0;
    cyc(1);
  endtask : wr

  task automatic clr;
    a_irq_clr = 1'h1;
    b_irq_clr = 1'h1;
    cyc(1);
    a_irq_clr = 1'h0;
    b_irq_clr = 1'h0;
    cyc(1);
  endtask : clr

  task automatic mode_b(input logic [1:0] m, input logic [1:0] sel);
    second_family_mode_reg = m;
    {measure_select_hi, measure_select_lo} = sel;
    b_mode_wr = 1'h1;
    cyc(1);
    b_mode_wr = 1'h0;
    cyc(1);
  endtask : mode_b

  task automatic do_reset(input logic [1:0] m);
    first_family_mode_reg = 2'h0;
    sys_rst = 1'h1;
    cyc(4);
    sys_rst = 1'h0;
    first_family_mode_reg = m;
    cyc(3);
  endtask : do_reset

  task automatic t_modes;
    do_reset(2'h3);
    chk1(a_irq_request_flag, 1'h1);
    do_reset(2'h2);
    chk1(a_irq_request_flag, 1'h1);
    for (int i = 0; i < 4; i++)
    begin
      first_family_mode_reg = frm[i];
      cyc(3);
      clr();
      first_family_mode_reg = tgt[i];
      cyc(3);
      chk1(a_irq_request_flag, 1'h1);
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_timer;
    first_family_mode_reg = 2'h0;
    wr(1'h0, 16'h0003);
    cyc(5);
    chk16(a_cnt_rd_data, 16'h0003);
    clr();
    count_start_reg_a[0] = 1'h1;
    wait_on(0, 16'h0002, 10);
    wait_on(0, 16'h0001, 10);
    wait_on(0, 16'h0000, 10);
    wait_on(0, 16'h0003, 10);
    wait_on(2, 16'h0001, 3);
    wr(1'h0, 16'h0007);
    wait_on(0, 16'h0007, 20);
    count_start_reg_a[0] = 1'h0;
    cyc(1);
    $display("test timer done");
  endtask : t_timer

  task automatic t_event(input logic up, input logic [15:0] v, input int n, input logic [15:0] e);
    first_family_mode_reg = 2'h1;
    up_down_select_reg = up;
    wr(1'h0, v);
    count_start_reg_a[0] = 1'h1;
    u_gtab_pins_model.trig_pulses(n, 4);
    chk16(a_cnt_rd_data, e);
    count_start_reg_a[0] = 1'h0;
    cyc(1);
    $display("test event done");
  endtask : t_event

  task automatic t_oneshot;
    first_family_mode_reg = 2'h2;
    count_src_sel = 2'h1;
    trigger_select_low = 1'h1;
    wr(1'h0, 16'h0040);
    clr();
    count_start_reg_a[0] = 1'h1;
    cyc(2);
    u_gtab_pins_model.trig_pulses(1, 0);
    wait_on(1, 16'h0001, 8);
    cyc(20);
    // count is only a few ticks below the reload value here, so only a retrigger brings it back
    u_gtab_pins_model.trig_pulses(1, 0);
    wait_on(0, 16'h0040, 30);
    count_start_reg_a[0] = 1'h0;
    cyc(1);
    chk1(timer_output_pin, 1'h0);
    chk16(a_cnt_rd_data, 16'h0040);
    chk1(a_irq_request_flag, 1'h0);
    cyc(1);
    chk1(a_irq_request_flag, 1'h1);
    $display("test oneshot done");
  endtask : t_oneshot

  task automatic t_pwm;
    first_family_mode_reg = 2'h3;
    count_src_sel = 2'h0;
    wr(1'h0, 16'h0010);
    clr();
    count_start_reg_a[0] = 1'h1;
    wait_on(1, 16'h0001, 6);
    count_start_reg_a[0] = 1'h0;
    cyc(1);
    chk1(timer_output_pin, 1'h0);
    chk1(a_irq_request_flag, 1'h1);
    clr();
    count_start_reg_a[0] = 1'h1;
    wait_on(1, 16'h0001, 6);
    wait_on(1, 16'h0000, 40);
    clr();
    count_start_reg_a[0] = 1'h0;
    cyc(3);
    chk1(timer_output_pin, 1'h0);
    chk1(a_irq_request_flag, 1'h0);
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_second;
    mode_b(2'h0, 2'h0);
    wr(1'h1, 16'h0100);
    count_start_reg_b = 8'he0;
    cyc(10);
    chk16(b_cnt_rd_data, 16'h0100);
    count_start_reg_b = 8'h00;
    count_start_reg_a = 8'h20;
    wait_on(3, 16'h00ff, 10);
    count_start_reg_a = 8'h00;
    mode_b(2'h2, 2'h2);
    clr();
    count_start_reg_a = 8'h20;
    cyc(2);
    u_gtab_pins_model.hold_event(1'h1, 10);
    chk1(b_irq_request_flag, 1'h0);
    u_gtab_pins_model.hold_event(1'h0, 10);
    chk1(b_irq_request_flag, 1'h1);
    clr();
    u_gtab_pins_model.hold_event(1'h1, 10);
    chk1(b_irq_request_flag, 1'h1);
    count_start_reg_a = 8'h00;
    mode_b(2'h2, 2'h0);
    wr(1'h1, 16'hfff0);
    clr();
    count_start_reg_a = 8'h20;
    wait_on(3, 16'hfffe, 30);
    // falling edge lands on the wrap edge, so it must be lost
    u_gtab_pins_model.hold_event(1'h0, 3);
    chk1(b_irq_request_flag, 1'h1);
    chk1(overflow_flag, 1'h1);
    clr();
    mode_b(2'h2, 2'h0);
    chk1(overflow_flag, 1'h0);
    chk1(b_irq_request_flag, 1'h0);
    mode_b(2'h2, 2'h1);
    chk1(b_irq_request_flag, 1'h1);
    count_start_reg_a = 8'h00;
    $display("test second family done");
  endtask : t_second

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  initial
  begin
    {clk, sys_rst, up_down_select_reg, trigger_select_low, one_shot_start_reg} = 5'h08;
    {a_cnt_wr_en, a_irq_clr, measure_select_hi, measure_select_lo, b_mode_wr} = 5'h00;
    {b_cnt_wr_en, b_irq_clr, count_start_reg_a, count_start_reg_b} = 18'h00000;
    {first_family_mode_reg, count_src_sel, second_family_mode_reg} = 6'h00;
    {a_cnt_wr_data, b_cnt_wr_data} = 32'h00000000;
    n_mismatch = 0;
    n_tests = 0;
    cyc(4);
    sys_rst = 1'h0;
    cyc(1);
    chk16(a_cnt_rd_data | b_cnt_rd_data, 16'h0000);
    chk1(timer_output_pin | a_irq_request_flag | b_irq_request_flag | overflow_flag, 1'h0);
    cyc(10);
    chk16(a_cnt_rd_data, 16'h0000);
    t_modes();
    t_timer();
    t_event(1'h0, 16'h0003, 2, 16'h0001);
    t_event(1'h1, 16'hfffe, 1, 16'hffff);
    t_oneshot();
    t_pwm();
    t_second();
    final_report();
  end

endmodule : gtab_timer_top_test
